// File: hdl/arc_pkg.sv
// Package of constants and types for the record channel control registers
package arc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_LGAIN = 8'h6C;
  localparam logic [7:0] ADR_RGAIN = 8'h6D;
  localparam logic [7:0] ADR_CTL1  = 8'h6E;
  localparam logic [7:0] ADR_CTL2  = 8'h6F;
  localparam logic [7:0] ADR_LVOL  = 8'h70;
  localparam logic [7:0] ADR_RVOL  = 8'h71;
  localparam logic [7:0] ADR_LPEAK = 8'h72;
  localparam logic [7:0] ADR_RPEAK = 8'h73;

  // Serial port address, value is arbitrary
  localparam logic [6:0] DEV_ADDR  = 7'h2A;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GAIN_MASK = 8'h3F;
  localparam logic [7:0] CTL2_MASK = 8'h13;
  localparam int         CTL2_BUF  = 4;
  localparam logic [5:0] GAIN_MAX  = 6'h30;
  localparam logic [5:0] PEAK_FLOOR = 6'h3F;
  localparam logic [7:0] RST_GAIN  = 8'h00;
  localparam logic [7:0] RST_CTL   = 8'h00;
  localparam logic [7:0] RST_VOL   = 8'h7F;
  localparam logic [6:0] VOL_UNITY = 7'h7F;
  localparam logic [8:0] SCALE_ONE = 9'h100;
  localparam logic [8:0] SCALE_MIN = 9'h001;
  localparam int         SMP_W     = 24;
  localparam int         PEAK_STEP = 6;

  // ----------------------------------------------------------------
  // Clock divider codes and limits
  // ----------------------------------------------------------------
  localparam logic [1:0] MCD_DIV2  = 2'h1;
  localparam logic [1:0] MCD_DIV3  = 2'h2;
  localparam logic [1:0] LIM_DIV1  = 2'h0;
  localparam logic [1:0] LIM_DIV2  = 2'h1;
  localparam logic [1:0] LIM_DIV3  = 2'h2;
  localparam logic [1:0] LIM_MOD2  = 2'h1;
  localparam logic [1:0] LIM_MOD4  = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mod_clk_sel;
    logic hpf_en;
    logic converter_sleep;
    logic analog_section_sleep;
    logic right_silence;
    logic left_silence;
    logic left_amp_sleep;
    logic right_amp_sleep;
  } arc_ctl1_s;

  typedef struct packed {
    logic [SMP_W-1:0] left;
    logic [SMP_W-1:0] right;
  } arc_pair_s;

  typedef struct packed {
    logic converter;
    logic analog;
    logic left_amp;
    logic right_amp;
    logic ref_buf;
  } arc_sleep_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } arc_req_s;

  typedef enum logic [3:0] {
    SP_IDLE, SP_DEV, SP_ACKA, SP_REG, SP_ACKR, SP_WR, SP_ACKW, SP_RD, SP_MACK
  } arc_sp_e;

endpackage : arc_pkg

// File: hdl/arc_record_regs.sv
// Record channel control and status registers with gain, clocking, volume and peak logic
`timescale 1ns/1ps
module arc_record_regs
  import arc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_B_I,
  // Serial control port
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  // Record samples
  input  wire arc_pair_s   SMP_IN_I,
  input  wire logic        SMP_VLD_I,
  output arc_pair_s        SMP_OUT_O,
  output logic             SMP_VLD_O,
  // Converter controls
  output logic [5:0]       LEFT_GAIN_O,
  output logic [5:0]       RIGHT_GAIN_O,
  output arc_sleep_s       SLEEP_O,
  output logic             HPF_EN_O,
  output logic             MCLK_CE_O,
  output logic             MOD_CE_O
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] gain_sat(input logic [7:0] c);
    gain_sat = (c[5:0] >= GAIN_MAX) ? GAIN_MAX : c[5:0];
  endfunction : gain_sat

  function automatic logic [8:0] vol_scale(input logic [7:0] c);
    if (c[6:0] == VOL_UNITY) vol_scale = SCALE_ONE;
    else if (c[6:0] == 7'h00) vol_scale = SCALE_MIN;
    else vol_scale = {1'b0, c[6:0], 1'b0};
  endfunction : vol_scale

  function automatic logic [SMP_W-1:0] scale_smp(input logic [SMP_W-1:0] s, input logic [7:0] v);
    logic signed [SMP_W+9:0] p;
    p = $signed(s) * $signed({1'b0, vol_scale(v)});
    scale_smp = p[SMP_W+7:8];
  endfunction : scale_smp

  // Coarse log: six codes per octave plus a three-bit mantissa trim
  function automatic logic [5:0] peak_code(input logic [SMP_W-1:0] s);
    logic [SMP_W-1:0] m, n;
    logic [4:0]       pos;
    logic [9:0]       acc;
    logic [2:0]       trim;
    m   = s[SMP_W-1] ? (~s + 24'h000001) : s;
    pos = 5'h00;
    for (int i = 0; i < SMP_W-1; i++) if (m[i]) pos = 5'(i);
    n = m << (5'd22 - pos);
    case (n[21:19])
      3'h0: trim = 3'h6;
      3'h1: trim = 3'h5;
      3'h2: trim = 3'h4;
      3'h3, 3'h4: trim = 3'h3;
      3'h5: trim = 3'h2;
      default: trim = 3'h1;
    endcase
    acc = 10'((5'd22 - pos) * PEAK_STEP) + {7'h00, trim};
    if (m[SMP_W-1]) peak_code = 6'h00;
    else if (m == '0 || acc > {4'h0, PEAK_FLOOR}) peak_code = PEAK_FLOOR;
    else peak_code = acc[5:0];
  endfunction : peak_code

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  arc_req_s   req;
  logic [7:0] rdata;

  arc_serial_port u_port (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (rst_n),
    .scl_i    (SCL_I),
    .sda_i    (SDA_I),
    .sda_oe_o (SDA_OE_O),
    .req_o    (req),
    .rdata_i  (rdata)
  );

  // Open-drain line only ever pulled low
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) SDA_O <= 1'b0;
    else SDA_O <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] lgain_ff, rgain_ff, ctl2_ff, lvol_ff, rvol_ff;
  arc_ctl1_s  ctl1_ff;
  logic [5:0] lpk_ff, rpk_ff;

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      lgain_ff <= RST_GAIN;
      rgain_ff <= RST_GAIN;
      ctl1_ff  <= RST_CTL;
      ctl2_ff  <= RST_CTL;
      lvol_ff  <= RST_VOL;
      rvol_ff  <= RST_VOL;
    end else if (req.wr) begin
      case (req.addr)
        ADR_LGAIN: lgain_ff <= req.data & GAIN_MASK;
        ADR_RGAIN: rgain_ff <= req.data & GAIN_MASK;
        ADR_CTL1:  ctl1_ff  <= req.data;
        ADR_CTL2:  ctl2_ff  <= req.data & CTL2_MASK;
        ADR_LVOL:  lvol_ff  <= req.data;
        ADR_RVOL:  rvol_ff  <= req.data;
        default: ; // Peak and unmapped offsets ignore writes
      endcase
    end
  end

  always_comb begin
    case (req.addr)
      ADR_LGAIN: rdata = lgain_ff;
      ADR_RGAIN: rdata = rgain_ff;
      ADR_CTL1:  rdata = ctl1_ff;
      ADR_CTL2:  rdata = ctl2_ff;
      ADR_LVOL:  rdata = lvol_ff;
      ADR_RVOL:  rdata = rvol_ff;
      ADR_LPEAK: rdata = {2'h0, lpk_ff};
      ADR_RPEAK: rdata = {2'h0, rpk_ff};
      default:   rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Converter control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      LEFT_GAIN_O  <= 6'h00;
      RIGHT_GAIN_O <= 6'h00;
      SLEEP_O      <= '0;
      HPF_EN_O     <= 1'b0;
    end else begin
      LEFT_GAIN_O       <= gain_sat(lgain_ff);
      RIGHT_GAIN_O      <= gain_sat(rgain_ff);
      SLEEP_O.converter <= ctl1_ff.converter_sleep;
      SLEEP_O.analog    <= ctl1_ff.analog_section_sleep;
      SLEEP_O.left_amp  <= ctl1_ff.left_amp_sleep;
      SLEEP_O.right_amp <= ctl1_ff.right_amp_sleep;
      SLEEP_O.ref_buf   <= ctl2_ff[CTL2_BUF];
      HPF_EN_O          <= ctl1_ff.hpf_en;
    end
  end

  // ----------------------------------------------------------------
  // Master clock divider and modulator clock
  // ----------------------------------------------------------------
  logic [1:0] mdiv_ff, mod_ff, mdiv_lim, mod_lim;

  assign mdiv_lim = (ctl2_ff[1:0] == MCD_DIV2) ? LIM_DIV2 :
                    (ctl2_ff[1:0] == MCD_DIV3) ? LIM_DIV3 : LIM_DIV1;
  assign mod_lim  = ctl1_ff.mod_clk_sel ? LIM_MOD4 : LIM_MOD2;

  // Sleeping converter holds both enables low
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      mdiv_ff   <= 2'h0;
      MCLK_CE_O <= 1'b0;
    end else if (ctl1_ff.converter_sleep) begin
      mdiv_ff   <= 2'h0;
      MCLK_CE_O <= 1'b0;
    end else begin
      MCLK_CE_O <= (mdiv_ff >= mdiv_lim);
      mdiv_ff   <= (mdiv_ff >= mdiv_lim) ? 2'h0 : mdiv_ff + 2'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      mod_ff   <= 2'h0;
      MOD_CE_O <= 1'b0;
    end else if (ctl1_ff.converter_sleep) begin
      mod_ff   <= 2'h0;
      MOD_CE_O <= 1'b0;
    end else begin
      MOD_CE_O <= MCLK_CE_O && (mod_ff >= mod_lim);
      if (MCLK_CE_O) mod_ff <= (mod_ff >= mod_lim) ? 2'h0 : mod_ff + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  logic [SMP_W-1:0] lsc, rsc;
  assign lsc = scale_smp(SMP_IN_I.left, lvol_ff);
  assign rsc = scale_smp(SMP_IN_I.right, rvol_ff);

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      SMP_OUT_O <= '0;
      SMP_VLD_O <= 1'b0;
    end else begin
      SMP_VLD_O <= SMP_VLD_I && !ctl1_ff.converter_sleep;
      if (SMP_VLD_I) begin
        SMP_OUT_O.left  <= ctl1_ff.left_silence ? '0 : lsc;
        SMP_OUT_O.right <= ctl1_ff.right_silence ? '0 : rsc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Peak level hold
  // ----------------------------------------------------------------
  logic [5:0] lnew, rnew;
  logic       lrd, rrd;
  assign lnew = peak_code(lsc);
  assign rnew = peak_code(rsc);
  assign lrd  = req.rd && (req.addr == ADR_LPEAK);
  assign rrd  = req.rd && (req.addr == ADR_RPEAK);

  // A read restarts the hold; a sample in the same cycle is kept
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      lpk_ff <= PEAK_FLOOR;
      rpk_ff <= PEAK_FLOOR;
    end else begin
      if (lrd) lpk_ff <= SMP_VLD_I ? lnew : PEAK_FLOOR;
      else if (SMP_VLD_I && lnew < lpk_ff) lpk_ff <= lnew;
      if (rrd) rpk_ff <= SMP_VLD_I ? rnew : PEAK_FLOOR;
      else if (SMP_VLD_I && rnew < rpk_ff) rpk_ff <= rnew;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);

  logic [3:0] gap_ff;
  logic       cfg_ok_ff;
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff    <= 4'h0;
      cfg_ok_ff <= 1'b0;
    end else begin
      gap_ff    <= MOD_CE_O ? 4'h1 : gap_ff + 4'h1;
      cfg_ok_ff <= (MOD_CE_O || cfg_ok_ff) && $stable(ctl2_ff) && $stable(ctl1_ff);
    end
  end

  sequence s_vol_unity_in;
    SMP_VLD_I && lvol_ff[6:0] == VOL_UNITY && !ctl1_ff.left_silence && !ctl1_ff.converter_sleep;
  endsequence

  a_left_gain_sat: assert property (lgain_ff[5:0] >= GAIN_MAX && $stable(lgain_ff)
    |=> LEFT_GAIN_O == GAIN_MAX) else $error("left gain not saturated");
  a_right_gain_val: assert property ($stable(rgain_ff)[*2] |-> RIGHT_GAIN_O ==
    ((rgain_ff[5:0] > GAIN_MAX) ? GAIN_MAX : rgain_ff[5:0])) else $error("right gain wrong");
  a_mod_ce_gap: assert property (MOD_CE_O && cfg_ok_ff |-> gap_ff == 4'(($past(ctl1_ff.mod_clk_sel) ? 3'h4 : 3'h2)
    * ($past(mdiv_lim) + 2'h1))) else $error("modulator rate wrong");
  a_left_mute_zero: assert property (SMP_VLD_O && $past(ctl1_ff.left_silence)
    |-> SMP_OUT_O.left == '0) else $error("left not silenced");
  a_sleep_follow: assert property (##1 SLEEP_O.converter == $past(ctl1_ff.converter_sleep)
    && !(SMP_VLD_O && $past(ctl1_ff.converter_sleep))) else $error("converter sleep wrong");
  a_refbuf_follow: assert property ($rose(ctl2_ff[CTL2_BUF]) |=> SLEEP_O.ref_buf)
    else $error("reference buffer sleep missed");
  a_vol_unity: assert property (s_vol_unity_in |=> SMP_OUT_O.left == $past(SMP_IN_I.left))
    else $error("unity volume altered sample");
  a_vol_half: assert property (SMP_VLD_I && rvol_ff[6:0] == 7'h40 && !ctl1_ff.right_silence
    |=> SMP_OUT_O.right == $past($signed(SMP_IN_I.right) >>> 1)) else $error("half volume wrong");
  a_peak_floor: assert property (lrd && !SMP_VLD_I |=> lpk_ff == PEAK_FLOOR)
    else $error("left peak not restarted");
  a_peak_hold: assert property (SMP_VLD_I && !rrd |=> rpk_ff <= $past(rpk_ff))
    else $error("right peak fell back");
  a_peak_readonly: assert property (req.wr && req.addr == ADR_LPEAK && !SMP_VLD_I && !lrd
    |=> $stable(lpk_ff)) else $error("peak register written");

endmodule : arc_record_regs

// File: hdl/arc_serial_port.sv
// Two-wire serial control port slave giving register read and write strobes
`timescale 1ns/1ps
module arc_serial_port
  import arc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe_o,
  // Register access
  output arc_req_s        req_o,
  input  wire logic [7:0] rdata_i
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic       scl_d_ff, sda_d_ff;
  logic       scl_rise, scl_fall, start_c, stop_c;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end

  assign scl_rise = scl_sync_ff[1] & ~scl_d_ff;
  assign scl_fall = ~scl_sync_ff[1] & scl_d_ff;
  assign start_c  = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
  assign stop_c   = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  arc_sp_e    st_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff, ptr_ff;
  logic       rw_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff    <= SP_IDLE;
      cnt_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      ptr_ff   <= 8'h00;
      rw_ff    <= 1'b0;
      sda_oe_o <= 1'b0;
      req_o    <= '0;
    end else begin
      req_o.wr <= 1'b0;
      req_o.rd <= 1'b0;
      // Address follows the pointer so read data is settled before a byte loads
      req_o.addr <= ptr_ff;
      if (start_c) begin
        st_ff    <= SP_DEV;
        cnt_ff   <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        st_ff    <= SP_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        case (st_ff)
          SP_DEV, SP_REG, SP_WR: begin
            sh_ff  <= {sh_ff[6:0], sda_sync_ff[1]};
            cnt_ff <= cnt_ff + 4'h1;
          end
          SP_RD:   cnt_ff <= cnt_ff + 4'h1;
          SP_MACK: begin
            if (sda_sync_ff[1]) st_ff <= SP_IDLE;
            else ptr_ff <= ptr_ff + 8'h01;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_ff)
          SP_DEV: if (cnt_ff == 4'h8) begin
            if (sh_ff[7:1] == DEV_ADDR) begin
              sda_oe_o <= 1'b1;
              rw_ff    <= sh_ff[0];
              st_ff    <= SP_ACKA;
            end else st_ff <= SP_IDLE;
          end
          SP_ACKA: begin
            cnt_ff <= 4'h0;
            if (rw_ff) begin
              // Hand the first read byte straight onto the line
              sh_ff      <= rdata_i;
              sda_oe_o   <= ~rdata_i[7];
              req_o.rd   <= 1'b1;
              req_o.addr <= ptr_ff;
              st_ff      <= SP_RD;
            end else begin
              sda_oe_o <= 1'b0;
              st_ff    <= SP_REG;
            end
          end
          SP_REG: if (cnt_ff == 4'h8) begin
            ptr_ff   <= sh_ff;
            sda_oe_o <= 1'b1;
            st_ff    <= SP_ACKR;
          end
          SP_WR: if (cnt_ff == 4'h8) begin
            req_o.wr   <= 1'b1;
            req_o.addr <= ptr_ff;
            req_o.data <= sh_ff;
            sda_oe_o   <= 1'b1;
            st_ff      <= SP_ACKW;
          end
          SP_ACKR, SP_ACKW: begin
            sda_oe_o <= 1'b0;
            cnt_ff   <= 4'h0;
            if (st_ff == SP_ACKW) ptr_ff <= ptr_ff + 8'h01;
            st_ff    <= SP_WR;
          end
          SP_RD: begin
            if (cnt_ff == 4'h8) begin
              sda_oe_o <= 1'b0;
              st_ff    <= SP_MACK;
            end else begin
              sda_oe_o <= ~sh_ff[6];
              sh_ff    <= {sh_ff[6:0], 1'b0};
            end
          end
          SP_MACK: begin
            sh_ff      <= rdata_i;
            sda_oe_o   <= ~rdata_i[7];
            req_o.rd   <= 1'b1;
            req_o.addr <= ptr_ff;
            cnt_ff     <= 4'h0;
            st_ff      <= SP_RD;
          end
          default: st_ff <= SP_IDLE;
        endcase
      end
    end
  end

endmodule : arc_serial_port

// File: sim/arc_host_model.sv
// Host controller model for the two-wire serial control port
`timescale 1ns/1ps
module arc_host_model
  import arc_pkg::*;
#(
  parameter int PHASE = 6
)
(
  // Clock
  input  wire logic       clk_i,
  // Serial pins
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_oe_o,
  // Read results
  output logic            rd_vld_o,
  output logic [7:0]      rd_data_o
);
  // ------------------------------------------------------------
  // Bus cycles; SCL idles high, so it stands still between frames
  // ------------------------------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    rd_vld_o = 1'b0;
    rd_data_o = 8'h00;
  end
  task automatic tick();
    repeat (PHASE) @(negedge clk_i);
  endtask : tick
  task automatic start();
    sda_oe_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_oe_o = 1'b1;
    tick();
    scl_o = 1'b0;
    tick();
  endtask : start
  task automatic stop();
    sda_oe_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_oe_o = 1'b0;
    tick();
  endtask : stop
  // Data moves only while SCL is low; the wire is sampled late in the high phase
  task automatic slot(input logic b, output logic s);
    sda_oe_o = ~b;
    tick();
    scl_o = 1'b1;
    tick();
    s = sda_i;
    scl_o = 1'b0;
    tick();
  endtask : slot
  task automatic tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(d[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask : tx
  task automatic rx(input logic last);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(last, s);
    rd_data_o = d;
    rd_vld_o = 1'b1;
    @(negedge clk_i);
    rd_vld_o = 1'b0;
  endtask : rx
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    tx({dev, 1'b0}, a0);
    tx(ptr, a1);
    tx(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr
  // Pointer write, repeated start, then n bytes with NACK on the last
  task automatic rd(input logic [7:0] ptr, input int n);
    logic a;
    start();
    tx({DEV_ADDR, 1'b0}, a);
    tx(ptr, a);
    start();
    tx({DEV_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) rx(i == n - 1);
    stop();
  endtask : rd
endmodule : arc_host_model

// File: sim/arc_record_regs_bench.sv
// Self-checking bench for the record channel control registers
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module arc_record_regs_bench
  import arc_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and tables
  // ------------------------------------------------------------
  localparam logic [7:0] RST_TAB [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h00};
  localparam logic [5:0] GTAB [5] = '{6'h00, 6'h01, 6'h2F, 6'h30, 6'h3F};
  localparam logic [7:0] C1TAB [5] = '{8'h20, 8'h10, 8'h02, 8'h01, 8'h00};
  localparam logic [4:0] SLTAB [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  localparam logic [7:0] MTAB [3] = '{8'h04, 8'h08, 8'h20};
  localparam logic [6:0] VTAB [3] = '{7'h7F, 7'h40, 7'h00};
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        vld_i = 1'b0;
  arc_pair_s   smp_in = '0;
  arc_pair_s   smp_out;
  arc_sleep_s  sleep;
  logic        scl, host_oe, sda_o, sda_oe, vld_o, mclk_ce, mod_ce, hpf, rd_vld, ok;
  logic [5:0]  lgain, rgain, c;
  logic [6:0]  vl = 7'h7F, vr = 7'h7F;
  logic [7:0]  rd_data;
  logic [31:0] rng = 32'h2315, r;
  logic [47:0] notes[$], expv;
  int          miscompares = 0, n_checks = 0, nm, nd, dv;
  wire         sda = (sda_oe ? sda_o : 1'b1) & ~host_oe;
  always #20 clk = ~clk;
  arc_record_regs i_dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .SMP_IN_I(smp_in), .SMP_VLD_I(vld_i), .SMP_OUT_O(smp_out), .SMP_VLD_O(vld_o),
    .LEFT_GAIN_O(lgain), .RIGHT_GAIN_O(rgain), .SLEEP_O(sleep), .HPF_EN_O(hpf), .MCLK_CE_O(mclk_ce),
    .MOD_CE_O(mod_ce));
  arc_host_model i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe), .rd_vld_o(rd_vld),
    .rd_data_o(rd_data));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  function automatic logic [23:0] scale(input logic [23:0] x, input logic [6:0] k);
    logic [47:0] p;
    p = {24'h0, x} * ((k == 7'h7F) ? 48'h100 : (k == 7'h00) ? 48'h1 : {40'h0, k, 1'b0});
    return p[31:8];
  endfunction : scale
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(DEV_ADDR, a, d, ok);
    `CHK(ok, 1'b1)
  endtask : wreg
  task automatic note(input logic [7:0] d);
    notes.push_back({40'h0, d});
  endtask : note
  // Samples are positive or at unity volume, so the scale is free of rounding questions
  task automatic smp(input logic [23:0] a, input logic [23:0] b, input logic ml, input logic mr, input logic drop);
    if (!drop) notes.push_back({ml ? 24'h0 : scale(a, vl), mr ? 24'h0 : scale(b, vr)});
    @(negedge clk);
    smp_in = {a, b};
    vld_i = 1'b1;
    @(negedge clk);
    vld_i = 1'b0;
  endtask : smp
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // Result monitor; an output with no note waiting is a mismatch
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_vld === 1'b1 || vld_o === 1'b1) begin
      expv = (notes.size() > 0) ? notes.pop_front() : 48'hX;
      `CHK((rd_vld === 1'b1) ? {40'h0, rd_data} : smp_out, expv)
    end
  end
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    conclude();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (6) @(negedge clk);
    foreach (RST_TAB[i]) note(RST_TAB[i]);
    i_host.rd(ADR_LGAIN, 9);
    for (int i = 0; i < 7; i++) begin
      r = xs();
      c = (i < 5) ? GTAB[i] : r[5:0];
      wreg(ADR_LGAIN, {2'b11, c});
      wreg(ADR_RGAIN, {2'b00, ~c});
      `CHK(lgain, (c > GAIN_MAX) ? GAIN_MAX : c)
      `CHK(rgain, (~c > GAIN_MAX) ? GAIN_MAX : ~c)
    end
    note({2'b00, c});
    i_host.rd(ADR_LGAIN, 1);
    for (int i = 0; i < 5; i++) begin
      wreg(ADR_CTL1, C1TAB[i]);
      wreg(ADR_CTL2, (i == 4) ? 8'hFF : 8'h00);
      `CHK(sleep, SLTAB[i])
    end
    note(8'h13);
    i_host.rd(ADR_CTL2, 1);
    // Enables counted over 120 cycles, a multiple of every period
    for (int d = 0; d < 8; d++) begin
      wreg(ADR_CTL2, {6'h00, d[2:1]});
      wreg(ADR_CTL1, {d[0], 7'h00});
      dv = (d[2:1] == 2'h1) ? 2 : (d[2:1] == 2'h2) ? 3 : 1;
      nm = 0;
      nd = 0;
      repeat (120) begin
        @(negedge clk);
        if (mclk_ce === 1'b1) nm++;
        if (mod_ce === 1'b1) nd++;
      end
      `CHK(nm, 120 / dv)
      `CHK(nd, 120 / (dv * (d[0] ? 4 : 2)))
    end
    wreg(ADR_CTL1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      vl = (i < 3) ? VTAB[i] : r[6:0];
      vr = (i < 3) ? VTAB[2 - i] : ~vl;
      wreg(ADR_LVOL, {1'b0, vl});
      wreg(ADR_RVOL, {1'b0, vr});
      r = xs();
      smp({1'b0, r[22:0]}, {1'b0, r[30:8]}, 1'b0, 1'b0, 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      wreg(ADR_CTL1, MTAB[i]);
      r = xs();
      smp({1'b0, r[22:0]}, {1'b0, r[30:8]}, i == 0, i == 1, i == 2);
    end
    vl = 7'h7F;
    vr = 7'h7F;
    wreg(ADR_CTL1, 8'h00);
    wreg(ADR_LVOL, 8'h7F);
    wreg(ADR_RVOL, 8'h7F);
    // Negative full scale is the only sample the detector reports as 0 dBFS
    smp(24'h800000, 24'h800000, 1'b0, 1'b0, 1'b0);
    note(8'h00);
    note(8'h00);
    i_host.rd(ADR_LPEAK, 2);
    wreg(ADR_LPEAK, 8'h15);
    wreg(ADR_RPEAK, 8'h2A);
    note(8'h3F);
    note(8'h3F);
    i_host.rd(ADR_LPEAK, 2);
    // A foreign device address is neither answered nor obeyed
    i_host.wr(DEV_ADDR ^ 7'h01, ADR_LVOL, 8'h11, ok);
    `CHK(ok, 1'b0)
    note(8'h7F);
    i_host.rd(ADR_LVOL, 1);
    repeat (4) @(negedge clk);
    `CHK(notes.size(), 0)
    conclude();
  end
endmodule : arc_record_regs_bench
